// ===== hdl/szac_consts.svh
// Constants for the secure zone access controller: bit map, register offsets,
// field positions and reset values.
// Assumes inclusion by bare name from the design module and the testbench files.
`ifndef SZAC_CONSTS_SVH
`define SZAC_CONSTS_SVH

// -----------------------------------------------------------------------------
// Bit address map
// -----------------------------------------------------------------------------
`define SZAC_MEM_BITS     480
`define SZAC_ADDR_W       9
`define SZAC_FAB_LO       9'h000
`define SZAC_FAB_HI       9'h00F
`define SZAC_ISS_LO       9'h010
`define SZAC_ISS_HI       9'h04F
`define SZAC_CODE_LO      9'h050
`define SZAC_CODE_HI      9'h05F
`define SZAC_TALLY_LO     9'h060
`define SZAC_TALLY_LIVE   9'h063
`define SZAC_TALLY_HI     9'h06F
`define SZAC_CGZ_LO       9'h070
`define SZAC_CGZ_HI       9'h0AF
`define SZAC_AREA_LO      9'h0B0
`define SZAC_WR_PERMIT    9'h0B0
`define SZAC_RD_PERMIT    9'h0B1
`define SZAC_AREA_HI      9'h1AF
`define SZAC_KEY_LO       9'h1B0
`define SZAC_KEY_HI       9'h1DF
// A fresh card leaves its four live tally bits erased, so the code can be presented.
`define SZAC_MEM_RESET    (480'hF << `SZAC_TALLY_LO)

// -----------------------------------------------------------------------------
// Register offsets and fields
// -----------------------------------------------------------------------------
`define SZAC_REG_CMD      8'h00
`define SZAC_REG_KEY_LO   8'h04
`define SZAC_REG_KEY_HI   8'h08
`define SZAC_REG_FUSE     8'h0C
`define SZAC_REG_STATUS   8'h10
`define SZAC_FUSE_FAB     0
`define SZAC_FUSE_ISS     1
`define SZAC_KEY_W        48
`define SZAC_CODE_W       16
`define SZAC_KEY_HI_W     16
`define SZAC_ZERO32       32'h0000_0000

`endif

// ===== hdl/szac_pkg.sv
// Types shared by the secure zone access controller.
// Assumes szac_consts.svh is on the include path.
package szac_pkg;
	typedef enum logic [2:0] {
		OP_READ  = 3'h0,
		OP_WRITE = 3'h1,
		OP_ERASE = 3'h2,
		OP_CODE  = 3'h3,
		OP_KEY   = 3'h4
	} szac_op_t;

	typedef struct packed {
		logic [6:0] rsv_hi;
		logic [8:0] addr;
		logic [6:0] rsv_mid;
		logic       data;
		logic [4:0] rsv_lo;
		szac_op_t   op;
	} szac_cmd_t;

	typedef struct packed {
		logic [25:0] rsv;
		logic        blocked;
		logic        rd_bit;
		logic        granted;
		logic        level2;
		logic        wipe_ok;
		logic        code_ok;
	} szac_status_t;
endpackage : szac_pkg

// ===== hdl/szac_access_ctrl.sv
// Access control of a serial secure memory card: holds the protected bit array
// and grants or refuses each read, single-bit write, erase and compare.
// Assumes an APB master on CLK and a level fuse pin synchronous to CLK.
//
// Summary of operation
// - Fabrication zone writable while fab fuse intact, read-only after it blows.
// - Blown issuer fuse also locks fabrication zone writes.
// - Issuer zone writable after verification before issuer fuse blows, read-only after.
// - Issuer zone reads always granted.
// - Matching access code sets code verified flag; guarded access needs it.
// - Access code rewritable in either level only after verification.
// - Verified code gates application area and code guarded zone writes, erases.
// - All four live tally bits cleared blocks guarded access until reset.
// - Tally erase refused unless code verified.
// - Any tally erase erases the whole sixteen-bit tally word.
// - Code guarded zone always readable, writable only after verification.
// - Bit 176 is area write permit, bit 177 area read permit.
// - Level 1 verified erase of any area bit erases the whole area.
// - Level 2 area erase needs code and wipe key verified.
// - Matching wipe key sets wipe key verified flag.
// - Area erases are unlimited and uncounted.
// - Area bit writes need verification, and in level 2 the write permit.
// - Area reads granted when read permit or code verified flag is set.
// - Wipe key writable in level 1 after verification, locked once issuer blown.
// - Level 2 when fuse pin low or issuer fuse blown, else level 1.
`include "szac_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module szac_access_ctrl (
	// Clock and reset
	input  wire logic        CLK,
	input  wire logic        RST,
	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// Card pin
	input  wire logic        FUSE_LEVEL_INPUT
);

	// -------------------------------------------------------------------------
	// Bus decode
	// -------------------------------------------------------------------------
	logic [`SZAC_MEM_BITS-1:0] mem_q;
	logic [`SZAC_MEM_BITS-1:0] mem_d;
	logic [`SZAC_KEY_W-1:0]    key_q;
	logic                      fab_blown_q;
	logic                      iss_blown_q;
	logic                      code_ok_q;
	logic                      wipe_ok_q;
	logic                      granted_q;
	logic                      rd_bit_q;
	logic [31:0]               prdata_q;

	wire setup     = PSEL & ~PENABLE;
	wire access    = PSEL & PENABLE;
	wire wr_acc    = access & PWRITE;
	wire hit_cmd   = PADDR == `SZAC_REG_CMD;
	wire hit_klo   = PADDR == `SZAC_REG_KEY_LO;
	wire hit_khi   = PADDR == `SZAC_REG_KEY_HI;
	wire hit_fuse  = PADDR == `SZAC_REG_FUSE;
	wire hit_stat  = PADDR == `SZAC_REG_STATUS;
	wire mapped    = hit_cmd | hit_klo | hit_khi | hit_fuse | hit_stat;
	wire exec      = wr_acc & hit_cmd;

	szac_pkg::szac_cmd_t cmd;
	assign cmd = szac_pkg::szac_cmd_t'(PWDATA);
	wire [`SZAC_ADDR_W-1:0] a = cmd.addr;

	// -------------------------------------------------------------------------
	// Security state
	// -------------------------------------------------------------------------
	wire level2     = ~FUSE_LEVEL_INPUT | iss_blown_q;
	wire tally_live = |mem_q[`SZAC_TALLY_LIVE:`SZAC_TALLY_LO];
	wire cv         = code_ok_q & tally_live;
	wire wr_permit  = mem_q[`SZAC_WR_PERMIT];
	wire rd_permit  = mem_q[`SZAC_RD_PERMIT];

	wire in_fab   = a <= `SZAC_FAB_HI;
	wire in_iss   = a >= `SZAC_ISS_LO & a <= `SZAC_ISS_HI;
	wire in_code  = a >= `SZAC_CODE_LO & a <= `SZAC_CODE_HI;
	wire in_tally = a >= `SZAC_TALLY_LO & a <= `SZAC_TALLY_HI;
	wire in_cgz   = a >= `SZAC_CGZ_LO & a <= `SZAC_CGZ_HI;
	wire in_area  = a >= `SZAC_AREA_LO & a <= `SZAC_AREA_HI;
	wire in_key   = a >= `SZAC_KEY_LO & a <= `SZAC_KEY_HI;

	// -------------------------------------------------------------------------
	// Permission decode
	// -------------------------------------------------------------------------
	wire rd_allow = in_fab | in_iss | in_tally | in_cgz
		| (in_code & cv)
		| (in_area & (rd_permit | cv))
		| (in_key & cv & ~level2);
	wire wr_allow = (in_fab & ~fab_blown_q & ~iss_blown_q)
		| (in_iss & ~iss_blown_q & cv)
		| (in_code & cv)
		| (in_tally & ~cmd.data)
		| (in_cgz & cv)
		| (in_area & cv & (~level2 | wr_permit))
		| (in_key & cv & ~level2 & ~iss_blown_q);
	wire era_tally = in_tally & cv;
	wire era_area  = in_area & cv & (~level2 | wipe_ok_q);
	wire era_bit   = wr_allow & ~in_tally & ~in_area;

	wire op_read  = exec & cmd.op == szac_pkg::OP_READ;
	wire op_write = exec & cmd.op == szac_pkg::OP_WRITE;
	wire op_erase = exec & cmd.op == szac_pkg::OP_ERASE;
	wire op_code  = exec & cmd.op == szac_pkg::OP_CODE;
	wire op_key   = exec & cmd.op == szac_pkg::OP_KEY;

	wire do_write   = op_write & wr_allow;
	wire do_etally  = op_erase & era_tally;
	wire do_earea   = op_erase & era_area;
	wire do_ebit    = op_erase & era_bit;
	wire code_match = key_q[`SZAC_CODE_W-1:0] == mem_q[`SZAC_CODE_HI:`SZAC_CODE_LO];
	wire key_match  = key_q == mem_q[`SZAC_KEY_HI:`SZAC_KEY_LO];
	wire set_code   = op_code & tally_live & code_match;
	wire set_wipe   = op_key & cv & key_match;
	wire granted_d  = (op_read & rd_allow) | do_write | do_etally | do_earea | do_ebit
		| set_code | set_wipe;

	// -------------------------------------------------------------------------
	// Bit array next value
	// -------------------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < `SZAC_MEM_BITS; i++) begin : g_bit
			localparam logic [`SZAC_ADDR_W-1:0] IDX = `SZAC_ADDR_W'(i);
			wire hit    = a == IDX;
			wire tallyb = IDX >= `SZAC_TALLY_LO & IDX <= `SZAC_TALLY_HI;
			wire areab  = IDX >= `SZAC_AREA_LO & IDX <= `SZAC_AREA_HI;
			wire wipe   = (do_etally & tallyb) | (do_earea & areab)
				| (do_ebit & hit);
			assign mem_d[i] = (do_write & hit) ? cmd.data : (wipe | mem_q[i]);
		end
	endgenerate

	// -------------------------------------------------------------------------
	// Registers
	// -------------------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (RST) begin
			mem_q <= `SZAC_MEM_RESET;
		end else begin
			mem_q <= mem_d;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			code_ok_q <= 1'b0;
			wipe_ok_q <= 1'b0;
		end else begin
			code_ok_q <= code_ok_q | set_code;
			wipe_ok_q <= wipe_ok_q | set_wipe;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			granted_q <= 1'b0;
			rd_bit_q  <= 1'b0;
		end else if (exec) begin
			granted_q <= granted_d;
			rd_bit_q  <= op_read & rd_allow & mem_q[a];
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			key_q <= {`SZAC_KEY_W{1'b0}};
		end else if (wr_acc & hit_klo) begin
			key_q[31:0] <= PWDATA;
		end else if (wr_acc & hit_khi) begin
			key_q[`SZAC_KEY_W-1:32] <= PWDATA[`SZAC_KEY_HI_W-1:0];
		end
	end

	// Fuses only ever blow; nothing clears them but reset.
	always_ff @(posedge CLK) begin
		if (RST) begin
			fab_blown_q <= 1'b0;
			iss_blown_q <= 1'b0;
		end else if (wr_acc & hit_fuse) begin
			fab_blown_q <= fab_blown_q | PWDATA[`SZAC_FUSE_FAB];
			iss_blown_q <= iss_blown_q | PWDATA[`SZAC_FUSE_ISS];
		end
	end

	// -------------------------------------------------------------------------
	// Read data
	// -------------------------------------------------------------------------
	szac_pkg::szac_status_t status;
	assign status = '{rsv: '0, blocked: ~tally_live, rd_bit: rd_bit_q, granted: granted_q,
		level2: level2, wipe_ok: wipe_ok_q, code_ok: cv};

	wire [31:0] fuse_word = {30'h0, iss_blown_q, fab_blown_q};
	wire [31:0] rd_mux = hit_stat ? 32'(status) : hit_fuse ? fuse_word : `SZAC_ZERO32;

	// Read data is captured in the setup phase; keys and commands read as zero.
	always_ff @(posedge CLK) begin
		if (RST) begin
			prdata_q <= `SZAC_ZERO32;
		end else if (setup) begin
			prdata_q <= PWRITE ? `SZAC_ZERO32 : rd_mux;
		end
	end

	assign PRDATA  = prdata_q;
	assign PREADY  = 1'b1;
	assign PSLVERR = access & ~mapped;

	// -------------------------------------------------------------------------
	// Checks
	// -------------------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	fab_lock_a: assert property (exec && in_fab && cmd.op != szac_pkg::OP_READ
		&& fab_blown_q |=> $stable(mem_q[`SZAC_FAB_HI:`SZAC_FAB_LO]))
		else $error("fabrication zone changed after its fuse blew");
	fab_iss_a: assert property (exec && in_fab && iss_blown_q
		|=> $stable(mem_q[`SZAC_FAB_HI:`SZAC_FAB_LO]))
		else $error("fabrication zone changed after issuer fuse blew");
	iss_lock_a: assert property (exec && in_iss && iss_blown_q
		|=> $stable(mem_q[`SZAC_ISS_HI:`SZAC_ISS_LO]))
		else $error("issuer zone changed after issuer fuse blew");
	iss_read_a: assert property (op_read && in_iss |=> granted_q)
		else $error("issuer zone read refused");
	code_set_a: assert property (op_code && tally_live && code_match
		|=> code_ok_q ##1 code_ok_q)
		else $error("code verified flag not set on match");
	code_wr_a: assert property (exec && in_code && !cv |=>
		$stable(mem_q[`SZAC_CODE_HI:`SZAC_CODE_LO]))
		else $error("access code changed without verification");
	blocked_a: assert property (!tally_live |-> !cv && !status.code_ok)
		else $error("access granted with tally exhausted");
	tally_erase_a: assert property (op_erase && in_tally
		|=> mem_q[`SZAC_TALLY_HI:`SZAC_TALLY_LO]
			== ($past(cv) ? 16'hFFFF : $past(mem_q[`SZAC_TALLY_HI:`SZAC_TALLY_LO])))
		else $error("tally erase wrong");
	area_erase_a: assert property (op_erase && in_area && cv
		&& (!level2 || wipe_ok_q) |=> &mem_q[`SZAC_AREA_HI:`SZAC_AREA_LO])
		else $error("area erase did not clear whole area");
	area_read_a: assert property (op_read && in_area
		|=> granted_q == $past(rd_permit | cv))
		else $error("area read decision wrong");
	flags_rst_a: assert property ($fell(RST) |-> !code_ok_q && !wipe_ok_q)
		else $error("verified flags survive reset");
	key_lock_a: assert property (exec && in_key && cmd.op != szac_pkg::OP_READ
		&& iss_blown_q |=> $stable(mem_q[`SZAC_KEY_HI:`SZAC_KEY_LO]))
		else $error("wipe key changed after issuer fuse blew");
	area_permit_a: assert property (op_write && in_area && level2 && !wr_permit
		|=> $stable(mem_q[`SZAC_AREA_HI:`SZAC_AREA_LO]))
		else $error("area written in level 2 without write permit");
	wipe_set_a: assert property (op_key && cv && key_match |=> wipe_ok_q)
		else $error("wipe key verified flag not set on match");
	area_level2_a: assert property (op_erase && in_area && level2 && !wipe_ok_q
		|=> !granted_q)
		else $error("level 2 area erase granted without wipe key");
	cgz_read_a: assert property (op_read && in_cgz |=> granted_q)
		else $error("code guarded zone read refused");

endmodule : szac_access_ctrl

`default_nettype wire

// ===== testbench/szac_reader.sv
// Card reader model: an APB master that issues register transfers and bit commands.
// Assumes szac_pkg is compiled first and szac_consts.svh is on the include path.
`include "szac_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module szac_reader (
	// Clock
	input  wire logic        CLK,
	// APB master
	output logic             PSEL,
	output logic             PENABLE,
	output logic             PWRITE,
	output logic      [7:0]  PADDR,
	output logic      [31:0] PWDATA,
	input  wire logic [31:0] PRDATA,
	input  wire logic        PREADY,
	input  wire logic        PSLVERR
);
	logic err;

	initial begin
		PSEL = 1'b0;
		PENABLE = 1'b0;
		PWRITE = 1'b0;
		PADDR = 8'h00;
		PWDATA = 32'h0000_0000;
		err = 1'b0;
	end

	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge CLK);
		PSEL <= 1'b1;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= wd;
		@(posedge CLK);
		PENABLE <= 1'b1;
		@(posedge CLK);
		while (PREADY !== 1'b1) @(posedge CLK);
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		// Released write data shows the inverse so nothing can lean on a stale value.
		PWDATA <= ~wd;
	endtask : xfer

	task automatic cmd(input szac_pkg::szac_op_t op, input logic [8:0] a, input logic d);
		szac_pkg::szac_cmd_t c;
		logic [31:0] rd;
		c = '0;
		c.op = op;
		c.addr = a;
		c.data = d;
		xfer(1'b1, `SZAC_REG_CMD, c, rd);
	endtask : cmd

	task automatic present_code(input logic [15:0] code, input logic [1:0] slot);
		logic [31:0] rd;
		cmd(szac_pkg::OP_WRITE, `SZAC_TALLY_LO + {7'h00, slot}, 1'b0);
		xfer(1'b1, `SZAC_REG_KEY_LO, {16'h0000, code}, rd);
		cmd(szac_pkg::OP_CODE, 9'h000, 1'b0);
	endtask : present_code

	task automatic wipe_tally();
		cmd(szac_pkg::OP_ERASE, `SZAC_TALLY_LO, 1'b0);
	endtask : wipe_tally
endmodule : szac_reader
`default_nettype wire

// ===== testbench/secure_zone_access_control_tb.sv
// Self-checking bench of the access controller driven by the card reader model.
// Assumes szac_pkg, szac_reader and szac_access_ctrl are compiled first.
`include "szac_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module secure_zone_access_control_tb;
	logic        clk;
	logic        rst;
	logic        fuse_pin;
	wire logic   psel, penable, pwrite, pready, pslverr;
	wire logic [7:0]  paddr;
	wire logic [31:0] pwdata, prdata;
	integer      num_errors, cmp_count, cycles;
	logic [31:0] rd;
	szac_pkg::szac_status_t s;

	szac_access_ctrl dut (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .FUSE_LEVEL_INPUT(fuse_pin));
	szac_reader u (.CLK(clk), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : print_verdict

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors = num_errors + 1;
			print_verdict();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count = cmp_count + 1;
		if (seen !== exp) begin
			num_errors = num_errors + 1;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic do_reset();
		@(posedge clk);
		rst <= 1'b1;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
	endtask : do_reset

	task automatic st();
		u.xfer(1'b0, `SZAC_REG_STATUS, 32'h0000_0000, rd);
		s = rd;
	endtask : st

	task automatic wr_bit(input logic [8:0] a, input logic d, input logic ok);
		u.cmd(szac_pkg::OP_WRITE, a, d);
		st();
		check(32'(s.granted), 32'(ok));
	endtask : wr_bit

	task automatic rd_bit(input logic [8:0] a, input logic ok, input logic v);
		u.cmd(szac_pkg::OP_READ, a, 1'b0);
		st();
		check({s.granted, s.rd_bit}, {ok, v});
	endtask : rd_bit

	// -------------------------------------------------------------------------
	// Scenarios
	// -------------------------------------------------------------------------
	task automatic t_reset_state();
		st();
		check(s, 32'h0000_0000);
	endtask : t_reset_state

	task automatic t_fab_fuse();
		wr_bit(`SZAC_FAB_LO + 9'h005, 1'b1, 1'b1);
		rd_bit(`SZAC_FAB_LO + 9'h005, 1'b1, 1'b1);
		u.xfer(1'b1, `SZAC_REG_FUSE, 32'h0000_0001, rd);
		u.xfer(1'b0, `SZAC_REG_FUSE, 32'h0000_0000, rd);
		check(rd, 32'h0000_0001);
		wr_bit(`SZAC_FAB_LO + 9'h005, 1'b0, 1'b0);
		rd_bit(`SZAC_FAB_LO + 9'h005, 1'b1, 1'b1);
	endtask : t_fab_fuse

	task automatic t_issuer_fuse();
		do_reset();
		wr_bit(`SZAC_FAB_HI, 1'b1, 1'b1);
		u.xfer(1'b1, `SZAC_REG_FUSE, 32'h0000_0002, rd);
		wr_bit(`SZAC_FAB_HI, 1'b0, 1'b0);
		rd_bit(`SZAC_FAB_HI, 1'b1, 1'b1);
		check(32'(s.level2), 32'h1);
		wr_bit(`SZAC_ISS_LO + 9'h010, 1'b1, 1'b0);
		rd_bit(`SZAC_ISS_LO + 9'h010, 1'b1, 1'b0);
		wr_bit(`SZAC_KEY_LO, 1'b1, 1'b0);
	endtask : t_issuer_fuse

	task automatic t_level_pin();
		do_reset();
		fuse_pin <= 1'b0;
		st();
		check(32'(s.level2), 32'h1);
		fuse_pin <= 1'b1;
		st();
		check(32'(s.level2), 32'h0);
	endtask : t_level_pin

	task automatic t_guarded();
		logic [8:0] tgt [4];
		tgt = '{`SZAC_CGZ_LO, `SZAC_CODE_LO, `SZAC_AREA_LO + 9'h005, `SZAC_KEY_LO};
		u.present_code(16'h1234, 2'h0);
		st();
		check(32'(s.code_ok), 32'h0);
		rd_bit(`SZAC_CGZ_LO + 9'h003, 1'b1, 1'b0);
		foreach (tgt[i])
			wr_bit(tgt[i], 1'b1, 1'b0);
		u.wipe_tally();
		st();
		check(32'(s.granted), 32'h0);
		u.cmd(szac_pkg::OP_ERASE, `SZAC_AREA_LO + 9'h020, 1'b0);
		st();
		check(32'(s.granted), 32'h0);
		u.cmd(szac_pkg::OP_KEY, 9'h000, 1'b0);
		st();
		check(32'(s.wipe_ok), 32'h0);
		rd_bit(`SZAC_AREA_LO + 9'h002, 1'b0, 1'b0);
		u.present_code(16'h0000, 2'h1);
		st();
		check(32'(s.code_ok), 32'h1);
		foreach (tgt[i])
			wr_bit(tgt[i], 1'b1, 1'b1);
		rd_bit(`SZAC_AREA_LO + 9'h005, 1'b1, 1'b1);
		u.xfer(1'b1, `SZAC_REG_KEY_LO, 32'h0000_0001, rd);
		u.xfer(1'b1, `SZAC_REG_KEY_HI, 32'h0000_0000, rd);
		u.cmd(szac_pkg::OP_KEY, 9'h000, 1'b0);
		st();
		check(32'(s.wipe_ok), 32'h1);
		u.cmd(szac_pkg::OP_ERASE, `SZAC_AREA_LO + 9'h020, 1'b0);
		st();
		check(32'(s.granted), 32'h1);
		rd_bit(`SZAC_AREA_LO + 9'h002, 1'b1, 1'b1);
		fuse_pin <= 1'b0;
		u.cmd(szac_pkg::OP_ERASE, `SZAC_AREA_LO + 9'h040, 1'b0);
		st();
		check(32'(s.granted), 32'h1);
		wr_bit(`SZAC_WR_PERMIT, 1'b0, 1'b1);
		wr_bit(`SZAC_AREA_LO + 9'h005, 1'b0, 1'b0);
		fuse_pin <= 1'b1;
		u.wipe_tally();
		st();
		check(32'(s.granted), 32'h1);
		rd_bit(`SZAC_TALLY_HI, 1'b1, 1'b1);
	endtask : t_guarded

	task automatic t_blocked();
		do_reset();
		for (int k = 0; k < 4; k++)
			u.present_code(16'h1234, 2'(k));
		st();
		check(32'(s.blocked), 32'h1);
		u.present_code(16'h0000, 2'h0);
		st();
		check(32'(s.code_ok), 32'h0);
	endtask : t_blocked

	task automatic t_unmapped();
		u.xfer(1'b0, 8'h14, 32'h0000_0000, rd);
		check(rd, 32'h0000_0000);
		check(32'(u.err), 32'h0000_0001);
	endtask : t_unmapped

	initial begin
		rst = 1'b1;
		fuse_pin = 1'b1;
		num_errors = 0;
		cmp_count = 0;
		cycles = 0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_reset_state();
		t_fab_fuse();
		t_issuer_fuse();
		t_level_pin();
		t_guarded();
		t_blocked();
		t_unmapped();
		print_verdict();
	end
endmodule : secure_zone_access_control_tb
`default_nettype wire
